// [dv/htm_cfg_model.sv]
// Purpose: Configuring party model feeding the datapath's static parameters
// Assumes: The bench changes set_in only while no valid sample is in flight
// Notes: Four canned target setups, values already normalized in Q1.15
`timescale 1ns/1ps
module htm_cfg_model (
  input wire logic [1:0] set_in,
  output logic [15:0] enc_black_out,
  output logic [15:0] enc_white_out,
  output logic [15:0] tb_norm_out,
  output logic [15:0] tw_norm_out
);
  // Pure decode of the set, so values stay put while set_in holds
  always_comb begin
    enc_black_out = 16'h0;
    enc_white_out = 16'h8000;
    tb_norm_out = 16'h0;
    tw_norm_out = 16'h8000;
    case (set_in)
      2'h1: tw_norm_out = 16'h6000;
      2'h2: enc_white_out = 16'hffff;
      2'h3: tb_norm_out = 16'h0200;
      default: tw_norm_out = 16'h8000;
    endcase
  end
endmodule

// [dv/htm_datapath_asserts.sv]
// Purpose: Port level checks of the tone mapping datapath
// Assumes: Parameters held stable while samples flow
// Notes: Unit span means black 0 and white 0x8000, so codes equal norms
`timescale 1ns/1ps
module htm_datapath_asserts (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic valid_in,
  input wire logic [2:0] mode_in,
  input wire logic [15:0] ch0_in,
  input wire logic [15:0] ch1_in,
  input wire logic [15:0] ch2_in,
  input wire logic [15:0] enc_black_in,
  input wire logic [15:0] enc_white_in,
  input wire logic [15:0] target_black_norm_in,
  input wire logic [15:0] target_white_norm_in,
  input wire logic valid_out,
  input wire logic [15:0] ch0_out,
  input wire logic [15:0] ch1_out,
  input wire logic [15:0] ch2_out
);
  logic [17:0] knee_raw;
  logic [15:0] knee;
  logic unit_span;
  logic flat;
  logic pch;
  // Knee from target white, clamped so white at 1.0 turns the roll-off off
  assign knee_raw = {2'h0, target_white_norm_in} + {3'h0, target_white_norm_in[15:1]};
  assign knee = (knee_raw < 18'h4000) ? 16'h0 :
    ((knee_raw >= 18'hc000) ? 16'h8000 : 16'(knee_raw - 18'h4000));
  assign unit_span = (enc_black_in == 16'h0) && (enc_white_in == 16'h8000);
  assign flat = unit_span && (target_black_norm_in == 16'h0) &&
    (target_white_norm_in >= 16'h8000);
  assign pch = valid_in && (mode_in == htm_pkg::HTM_PER_CHANNEL);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // Result lands exactly three edges after the capture
  sequence s_out;
    ##3 valid_out;
  endsequence
  sequence s_no_out;
    ##3 !valid_out;
  endsequence
  property p_lat;
    valid_in |-> s_out;
  endproperty
  a_lat: assert property (p_lat) else $error("valid_out late or missing");
  property p_idle;
    !valid_in |-> s_no_out;
  endproperty
  a_idle: assert property (p_idle) else $error("valid_out without a sample");
  property p_rst;
    disable iff (1'b0) reset_in |=> !valid_out && (ch0_out == 16'h0);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_pass;
    pch && unit_span && (target_black_norm_in == 16'h0) && (ch0_in < knee)
      |-> ##3 (ch0_out == $past(ch0_in, 3));
  endproperty
  a_pass: assert property (p_pass) else $error("code below knee altered");
  property p_top;
    pch && unit_span && (target_black_norm_in == 16'h0) && (target_white_norm_in < 16'h8000)
      && (ch0_in >= 16'h8000) |-> ##3 (ch0_out <= target_white_norm_in + 16'h4)
      && (ch0_out + 16'h4 >= target_white_norm_in);
  endproperty
  a_top: assert property (p_top) else $error("full scale not mapped to white");
  property p_lift;
    pch && unit_span && (target_white_norm_in >= 16'h8000) && (ch0_in == 16'h0)
      |-> ##3 (ch0_out == target_black_norm_in);
  endproperty
  a_lift: assert property (p_lift) else $error("black not lifted by offset");
  property p_chroma;
    valid_in && (mode_in == htm_pkg::HTM_CHROMA) && flat && (ch0_in <= 16'h8000)
      |-> ##3 (ch1_out == $past(ch1_in, 3)) && (ch2_out == $past(ch2_in, 3));
  endproperty
  a_chroma: assert property (p_chroma) else $error("chroma scaled at unity");
  property p_lanes;
    valid_in && (mode_in != htm_pkg::HTM_CHROMA) && (mode_in != htm_pkg::HTM_LUMINANCE)
      && flat && (ch1_in <= 16'h8000) && (ch2_in <= 16'h8000)
      |-> ##3 (ch1_out == $past(ch1_in, 3)) && (ch2_out == $past(ch2_in, 3));
  endproperty
  a_lanes: assert property (p_lanes) else $error("side lanes not mapped alone");
endmodule

// [dv/tb_top.sv]
// Purpose: Self-checking bench of the tone mapping datapath
// Assumes: Three cycle latency, parameters switched only while idle
// Notes: Expected results queued by the driver, popped by the monitor
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [15:0] e0;
    logic [15:0] e1;
    logic [15:0] e2;
    logic [15:0] tol;
  } htm_exp_s;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic valid_in = 1'b0;
  logic [2:0] mode_in = 3'h1;
  logic [15:0] ch0_in = 16'h0;
  logic [15:0] ch1_in = 16'h0;
  logic [15:0] ch2_in = 16'h0;
  logic [1:0] cfg_set = 2'h0;
  logic [15:0] eb, ew, tbn, twn, o0, o1, o2, r0, r1, r2;
  logic valid_out;
  logic [31:0] seed = 32'hcbb7;
  htm_exp_s exp_q[$];
  htm_exp_s e;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  htm_cfg_model u_cfg (.set_in(cfg_set), .enc_black_out(eb), .enc_white_out(ew),
    .tb_norm_out(tbn), .tw_norm_out(twn));
  htm_datapath u_dut (.mclk_in(mclk_in), .reset_in(reset_in), .valid_in(valid_in),
    .mode_in(mode_in), .ch0_in(ch0_in), .ch1_in(ch1_in), .ch2_in(ch2_in),
    .enc_black_in(eb), .enc_white_in(ew), .target_black_norm_in(tbn),
    .target_white_norm_in(twn), .valid_out(valid_out), .ch0_out(o0), .ch1_out(o1),
    .ch2_out(o2));

  always #10 mclk_in = ~mclk_in;

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  // Tolerance covers the truncating fixed-point arithmetic of the curve
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input logic [15:0] tol);
    logic [16:0] d;
    d = (seen > want) ? 17'(seen - want) : 17'(want - seen);
    checked++;
    if ((^seen === 1'bx) || (d > {1'b0, tol})) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic send(input logic [2:0] m, input logic [15:0] a, b, c, input htm_exp_s x);
    mode_in = m;
    ch0_in = a;
    ch1_in = b;
    ch2_in = c;
    valid_in = 1'b1;
    exp_q.push_back(x);
    @(negedge mclk_in);
  endtask

  task automatic idle(input int n);
    valid_in = 1'b0;
    repeat (n) @(negedge mclk_in);
  endtask

  task automatic give_verdict();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Monitor: every result must match the oldest queued note
  always @(negedge mclk_in) begin
    if (!reset_in && valid_out !== 1'b0) begin
      if (exp_q.size() == 0) begin
        check(16'h1, 16'h0, 16'h0);
      end else begin
        e = exp_q.pop_front();
        check(o0, e.e0, e.tol);
        check(o1, e.e1, e.tol);
        check(o2, e.e2, e.tol);
      end
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(negedge mclk_in);
    reset_in = 1'b0;
    // Identity setup: random codes return untouched, odd mode acts per channel
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      r0 = {1'b0, seed[14:0]};
      r1 = {1'b0, seed[30:16]};
      r2 = {1'b0, seed[22:8]};
      send(i[0] ? 3'h3 : 3'h1, r0, r1, r2, {r0, r1, r2, 16'h0});
    end
    send(3'h1, 16'hffff, 16'h8000, 16'h0, {16'h8000, 16'h8000, 16'h0, 16'h0});
    send(3'h2, r0, seed[15:0], seed[31:16], {r0, seed[15:0], seed[31:16], 16'h0});
    idle(5);
    // Roll-off setup: knee at 0x5000, full scale lands on target white
    cfg_set = 2'h1;
    idle(1);
    send(3'h1, 16'h8000, 16'h4000, 16'h5000, {16'h6000, 16'h4000, 16'h5000, 16'h4});
    send(3'h2, 16'h8000, 16'h1000, 16'hf000, {16'h6000, 16'h0c00, 16'hf400, 16'h8});
    idle(5);
    // Lift setup: offset tapers to nothing at full scale
    cfg_set = 2'h3;
    idle(1);
    send(3'h1, 16'h0, 16'h4000, 16'h8000, {16'h0200, 16'h4020, 16'h8000, 16'h2});
    idle(5);
    // Full range setup, linear luminance mode on grey and black
    cfg_set = 2'h2;
    idle(1);
    send(3'h4, 16'h4000, 16'h4000, 16'h4000, {16'h4000, 16'h4000, 16'h4000, 16'h100});
    send(3'h4, 16'h0, 16'h0, 16'h0, {16'h0, 16'h0, 16'h0, 16'h0});
    idle(5);
    // Reset in flight must drop the sample; a single reset edge clears every stage so no stale
    // result reaches the monitor, and the first sample after release must pass
    valid_in = 1'b1;
    @(negedge mclk_in);
    reset_in = 1'b1;
    idle(1);
    reset_in = 1'b0;
    send(3'h1, 16'h0, 16'hffff, 16'h0, {16'h0, 16'hffff, 16'h0, 16'h0});
    idle(6);
    if (exp_q.size() != 0) begin
      check(16'(exp_q.size()), 16'h0, 16'h0);
    end
    give_verdict();
  end
endmodule

bind htm_datapath htm_datapath_asserts u_chk (.mclk_in(mclk_in), .reset_in(reset_in),
  .valid_in(valid_in), .mode_in(mode_in), .ch0_in(ch0_in), .ch1_in(ch1_in), .ch2_in(ch2_in),
  .enc_black_in(enc_black_in), .enc_white_in(enc_white_in),
  .target_black_norm_in(target_black_norm_in), .target_white_norm_in(target_white_norm_in),
  .valid_out(valid_out), .ch0_out(ch0_out), .ch1_out(ch1_out), .ch2_out(ch2_out));

// [rtl/htm_curve.sv]
// Purpose: One lane of the electrical_tone_map curve, code in, code out
// Assumes: Parameters held stable while samples flow
// Notes: One register stage; the output is registered
`timescale 1ns/1ps
module htm_curve (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [15:0] code_in,
  input wire logic [15:0] enc_black_in,
  input wire logic [15:0] enc_white_in,
  input wire logic [15:0] target_black_norm_in,
  input wire logic [15:0] target_white_norm_in,
  output logic [15:0] code_out
);
  typedef struct packed {
    logic [15:0] code;
  } htm_curve_s;

  htm_curve_s st_ff;
  htm_curve_s nxt_st;

  // Whole curve in one combinational pass, straight on code values
  always_comb begin
    logic [15:0] span, e1, ks, t, t2, t3, e2, u, u2, u4, e3;
    logic [31:0] q;
    logic signed [18:0] ks_s;
    logic signed [19:0] h00, h10, h01;
    logic signed [39:0] acc;
    span = '0;
    e1 = '0;
    ks = '0;
    t = '0;
    t2 = '0;
    t3 = '0;
    e2 = '0;
    u = '0;
    u2 = '0;
    u4 = '0;
    e3 = '0;
    q = '0;
    ks_s = '0;
    h00 = '0;
    h10 = '0;
    h01 = '0;
    acc = '0;
    nxt_st = st_ff;
    // Zero span would divide by zero, so it falls back to one code
    span = (enc_white_in > enc_black_in) ? enc_white_in - enc_black_in
         : htm_pkg::SPAN_MIN;
    if (code_in > enc_black_in) begin
      q = htm_pkg::udiv({1'b0, code_in - enc_black_in, 15'h0}, span);
    end
    e1 = htm_pkg::sat16(q, htm_pkg::ONE);
    // Knee point, negative results clamp to zero
    ks_s = $signed({1'b0, 18'(({2'b0, target_white_norm_in} * 3) >> 1)})
         - $signed({3'b0, htm_pkg::HALF});
    if (ks_s < 0) ks = '0;
    else ks = htm_pkg::sat16(32'(ks_s), htm_pkg::ONE);
    if (e1 < ks || ks == htm_pkg::ONE) begin
      e2 = e1;
    end else begin
      t = htm_pkg::sat16(htm_pkg::udiv({1'b0, e1 - ks, 15'h0}, htm_pkg::ONE - ks),
                         htm_pkg::ONE);
      t2 = htm_pkg::qmul(t, t);
      t3 = htm_pkg::qmul(t2, t);
      // Hermite weights, signed because h10 and h01 leave zero mid-span
      h00 = 20'(2 * $signed({4'b0, t3}) - 3 * $signed({4'b0, t2})
          + $signed({4'b0, htm_pkg::ONE}));
      h10 = 20'($signed({4'b0, t3}) - 2 * $signed({4'b0, t2}) + $signed({4'b0, t}));
      h01 = 20'(3 * $signed({4'b0, t2}) - 2 * $signed({4'b0, t3}));
      acc = h00 * $signed({4'b0, ks}) + h10 * $signed({4'b0, htm_pkg::ONE - ks})
          + h01 * $signed({4'b0, target_white_norm_in});
      acc = acc >>> htm_pkg::FRAC;
      if (acc < 0) e2 = '0;
      else e2 = htm_pkg::sat16(acc[31:0], htm_pkg::ONE);
    end
    // Tapered black lift: full offset at black, none at white
    u = htm_pkg::ONE - e2;
    u2 = htm_pkg::qmul(u, u);
    u4 = htm_pkg::qmul(u2, u2);
    e3 = htm_pkg::sat16({16'h0, e2} + {16'h0, htm_pkg::qmul(target_black_norm_in, u4)},
                        htm_pkg::ONE);
    // Back to the mastering code range
    nxt_st.code = htm_pkg::sat16({16'h0, htm_pkg::qmul(e3, span)} + {16'h0, enc_black_in},
                                 htm_pkg::LIN_MAX);
  end

  // Single state register; code reset keeps the output defined
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign code_out = st_ff.code;
endmodule

// [rtl/htm_datapath.sv]
// Purpose: Tone mapping datapath, three lanes, selectable application mode
// Assumes: One sample per clock, upstream never stalls, parameters stable
// Notes: Fixed latency of three clocks from input to output
//   Mode may change every sample; parameters may not while samples fly
`timescale 1ns/1ps
module htm_datapath (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic valid_in,
  input wire logic [2:0] mode_in,
  input wire logic [15:0] ch0_in,
  input wire logic [15:0] ch1_in,
  input wire logic [15:0] ch2_in,
  input wire logic [15:0] enc_black_in,
  input wire logic [15:0] enc_white_in,
  input wire logic [15:0] target_black_norm_in,
  input wire logic [15:0] target_white_norm_in,
  output logic valid_out,
  output logic [15:0] ch0_out,
  output logic [15:0] ch1_out,
  output logic [15:0] ch2_out
);
  // Stages A, B and C; mode rides with each sample so it may change per cycle
  typedef struct packed {
    logic vld_a;
    htm_pkg::htm_mode_e mode_a;
    logic [2:0][15:0] ch_a;
    logic [2:0][15:0] tm_a;
    logic [15:0] ylin_a;
    logic vld_b;
    htm_pkg::htm_mode_e mode_b;
    logic [2:0][15:0] ch_b;
    logic [15:0] ylin_b;
    logic vld_o;
    logic [2:0][15:0] ch_o;
  } htm_dp_s;

  htm_dp_s st_ff;
  htm_dp_s nxt_st;
  // Curve results, one register late, line up with stage B
  logic [2:0][15:0] tm_code;

  // Linear value to code: octave found by leading one, straight line inside
  // Accuracy is a few percent: fine for a gain ratio, too coarse for display codes
  function automatic logic [15:0] lin_to_code(input logic [15:0] v);
    logic [4:0] e;
    logic [15:0] frac, seg;
    logic [31:0] prod;
    e = '0;
    // Highest set bit picks the octave
    for (int i = 0; i < 16; i++) begin
      if (v[i]) e = 5'(i);
    end
    frac = v - 16'(32'h1 << e);
    seg = htm_pkg::PQ_TAB[e + 5'h1] - htm_pkg::PQ_TAB[e];
    prod = (seg * frac) >> e;
    // Zero has no octave; the arithmetic above is discarded for it
    if (v == '0) return '0;
    return htm_pkg::sat16({16'h0, htm_pkg::PQ_TAB[e]} + prod, htm_pkg::LIN_MAX);
  endfunction

  // Code back to linear; the segment divide never sees zero, table is rising
  function automatic logic [15:0] code_to_lin(input logic [15:0] c);
    logic [4:0] e;
    logic [15:0] seg;
    logic [31:0] q;
    e = '0;
    // Last table entry not above the code picks the segment
    for (int i = 0; i < 16; i++) begin
      if (c >= htm_pkg::PQ_TAB[i]) e = 5'(i);
    end
    seg = htm_pkg::PQ_TAB[e + 5'h1] - htm_pkg::PQ_TAB[e];
    q = htm_pkg::udiv(32'(c - htm_pkg::PQ_TAB[e]) << e, seg);
    if (c < htm_pkg::PQ_TAB[0]) return '0;
    return htm_pkg::sat16(q + (32'h1 << e), htm_pkg::LIN_MAX);
  endfunction

  // Three identical curve lanes; lanes 1 and 2 idle in the single-lane modes
  // One shared curve would save area but could not keep one sample a clock
  for (genvar g = 0; g < 3; g++) begin : g_lane
    htm_curve u_curve (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .code_in(st_ff.tm_a[g]),
      .enc_black_in(enc_black_in),
      .enc_white_in(enc_white_in),
      .target_black_norm_in(target_black_norm_in),
      .target_white_norm_in(target_white_norm_in),
      .code_out(tm_code[g])
    );
  end

  // Next state of all three stages; each stage reads only the one before it
  always_comb begin
    htm_pkg::htm_mode_e m;
    logic [31:0] ysum;
    logic [15:0] i1, i2, lo, hi, ratio, y2;
    logic [31:0] q;
    logic signed [32:0] cs;
    // Locals start at zero, m at per-channel, so that no path leaves a latch behind
    m = htm_pkg::HTM_PER_CHANNEL;
    ysum = '0;
    i1 = '0;
    i2 = '0;
    lo = '0;
    hi = '0;
    ratio = '0;
    y2 = '0;
    q = '0;
    cs = '0;
    nxt_st = st_ff;

    // Stage A: capture, pick lane operands; unknown mode codes act per-channel
    case (mode_in)
      htm_pkg::HTM_CHROMA: m = htm_pkg::HTM_CHROMA;
      htm_pkg::HTM_LUMINANCE: m = htm_pkg::HTM_LUMINANCE;
      default: m = htm_pkg::HTM_PER_CHANNEL;
    endcase
    // Luminance is formed for every sample but used only in mode 100
    // Weights sum to exactly 1.0, so full scale in cannot saturate the sum
    ysum = 32'(htm_pkg::Y_WR * ch0_in) + 32'(htm_pkg::Y_WG * ch1_in)
         + 32'(htm_pkg::Y_WB * ch2_in);
    nxt_st.vld_a = valid_in;
    nxt_st.mode_a = m;
    nxt_st.ch_a = {ch2_in, ch1_in, ch0_in};
    nxt_st.ylin_a = htm_pkg::sat16(ysum >> htm_pkg::FRAC, htm_pkg::LIN_MAX);
    case (m)
      htm_pkg::HTM_LUMINANCE: begin
        // Luminance goes to the curve in the encoded domain
        nxt_st.tm_a = {16'h0, 16'h0, lin_to_code(nxt_st.ylin_a)};
      end
      htm_pkg::HTM_CHROMA: begin
        nxt_st.tm_a = {16'h0, 16'h0, ch0_in};
      end
      default: begin
        nxt_st.tm_a = {ch2_in, ch1_in, ch0_in};
      end
    endcase

    // Stage B: originals wait beside the curve register
    // Nothing is computed here; the stage only buys the curve its clock
    nxt_st.vld_b = st_ff.vld_a;
    nxt_st.mode_b = st_ff.mode_a;
    nxt_st.ch_b = st_ff.ch_a;
    nxt_st.ylin_b = st_ff.ylin_a;

    // Stage C: recombine per mode
    nxt_st.vld_o = st_ff.vld_b;
    nxt_st.ch_o = tm_code;
    case (st_ff.mode_b)
      htm_pkg::HTM_CHROMA: begin
        // lo/hi is the smaller of old/new and new/old, so chroma only shrinks
        i1 = st_ff.ch_b[0];
        i2 = tm_code[0];
        lo = (i1 < i2) ? i1 : i2;
        hi = (i1 < i2) ? i2 : i1;
        // Both zero means no change, so unity stands in for the ratio
        if (hi == '0) ratio = htm_pkg::RATIO_UNITY;
        else ratio = htm_pkg::sat16(htm_pkg::udiv({1'b0, lo, 15'h0}, hi), htm_pkg::ONE);
        // Lane 0 carries the mapped intensity itself
        nxt_st.ch_o[0] = i2;
        for (int k = 1; k < 3; k++) begin
          // Chroma is signed two's complement around zero
          cs = ($signed({{17{st_ff.ch_b[k][15]}}, st_ff.ch_b[k]})
              * $signed({17'h0, ratio})) >>> htm_pkg::FRAC;
          nxt_st.ch_o[k] = cs[15:0];
        end
      end
      htm_pkg::HTM_LUMINANCE: begin
        // Decoding the mapped code brings the new luminance back to linear
        y2 = code_to_lin(tm_code[0]);
        for (int k = 0; k < 3; k++) begin
          // Black luminance leaves the pixel untouched rather than divide by zero
          if (st_ff.ylin_b == '0) begin
            nxt_st.ch_o[k] = st_ff.ch_b[k];
          end else begin
            q = htm_pkg::udiv(32'(st_ff.ch_b[k] * y2), st_ff.ylin_b);
            nxt_st.ch_o[k] = htm_pkg::sat16(q, htm_pkg::LIN_MAX);
          end
        end
      end
      default: begin
        // Per-channel and unknown codes take the three curve lanes as they are
        nxt_st.ch_o = tm_code;
      end
    endcase
  end

  // Whole pipeline state; reset clears every valid and data bit
  // Mode fields reset to per-channel so the enum never holds an illegal code
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_ff <= '0;
      st_ff.mode_a <= htm_pkg::HTM_PER_CHANNEL;
      st_ff.mode_b <= htm_pkg::HTM_PER_CHANNEL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs are plain taps of the output stage flip-flops
  assign valid_out = st_ff.vld_o;
  assign ch0_out = st_ff.ch_o[0];
  assign ch1_out = st_ff.ch_o[1];
  assign ch2_out = st_ff.ch_o[2];
endmodule

// [rtl/htm_pkg.sv]
// Purpose: Shared constants, types and arithmetic for the tone mapping datapath
// Assumes: 16-bit code words, normalized values in unsigned Q1.15 (1.0 = 0x8000)
// Notes: Encode table is a coarse piecewise fit of the perceptual curve
package htm_pkg;
  localparam int W = 16;
  localparam int FRAC = 15;
  localparam logic [15:0] ONE = 16'h8000;
  localparam logic [15:0] HALF = 16'h4000;
  localparam logic [15:0] SPAN_MIN = 16'h0001;
  localparam logic [15:0] RATIO_UNITY = 16'h8000;
  // Linear luminance weights in Q1.15, summing to exactly 1.0
  localparam logic [15:0] Y_WR = 16'h21a0;
  localparam logic [15:0] Y_WG = 16'h56c9;
  localparam logic [15:0] Y_WB = 16'h0797;
  // Code at linear value 2^e, e = 0..16 (index 16 is full scale)
  localparam logic [16:0][15:0] PQ_TAB = {
    16'hffff, 16'he700, 16'hd100, 16'hc520, 16'hb330, 16'ha140, 16'h8f50, 16'h7d70,
    16'h6b80, 16'h5c20, 16'h4cd0, 16'h3eb0, 16'h32b0, 16'h2870, 16'h2000, 16'h1910,
    16'h1370};
  localparam logic [15:0] LIN_MAX = 16'hffff;
  localparam int LATENCY = 3;

  typedef enum logic [2:0] {
    HTM_PER_CHANNEL = 3'b001,
    HTM_CHROMA = 3'b010,
    HTM_LUMINANCE = 3'b100
  } htm_mode_e;

  // Restoring unsigned divide; a zero divisor yields all ones, callers guard it
  function automatic logic [31:0] udiv(input logic [31:0] n, input logic [15:0] d);
    logic [32:0] r;
    logic [31:0] q;
    r = '0;
    q = '0;
    for (int i = 31; i >= 0; i--) begin
      r = {r[31:0], n[i]};
      if (r >= {17'h0, d}) begin
        r = r - {17'h0, d};
        q[i] = 1'b1;
      end
    end
    return q;
  endfunction

  // Saturate a wide unsigned value to 16 bits at a given ceiling
  function automatic logic [15:0] sat16(input logic [31:0] v, input logic [15:0] top);
    return (v > {16'h0, top}) ? top : v[15:0];
  endfunction

  // Q1.15 product, kept as a full 16-bit result
  function automatic logic [15:0] qmul(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    p = a * b;
    return sat16({1'b0, p[31:1]} >> (FRAC - 1), LIN_MAX);
  endfunction
endpackage
